// file: logic/btc_pkg.sv
// Constants for the byte timer control block
// Functional notes
// RULE_01: Control bit 7 starts or stops the counter, reads back the run state, and is 0 after reset.
// RULE_02: Control bit 6 picks repeating modulo-N (0, default) or single pass (1).
// RULE_03: Control bit 5 reads 1 after a time-out; writing 1 clears it, writing 0 leaves it.
// RULE_04: Control bits 4:3 pick the count clock: system clock, /2, /4 or /8, default 00.
// RULE_05: Control bit 2 at 0 (default) blocks the capture interrupt request.
// RULE_06: Control bit 2 at 1 lets the capture event raise its interrupt request.
// RULE_07: The high level hold register is a full read/write byte.
// RULE_08: The low level hold register is a full read/write byte.
// RULE_09: The wide timer low hold byte is a full read/write byte.
// RULE_10: Edge detection takes its input from port3_bit1 or port2_bit0.
// RULE_11: The time-out flag is set each time the counter reaches terminal count.
// RULE_12: Modulo-N reloads from the hold registers and runs on; single pass stops and clears run. The count reloads from the low level hold register only.
package btc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] BTC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] BTC_OFF_LOW    = 8'h04;
  localparam logic [7:0] BTC_OFF_HIGH   = 8'h05;
  localparam logic [7:0] BTC_OFF_WLOW   = 8'h06;
  localparam logic [7:0] BTC_OFF_STATUS = 8'h08;
  localparam logic [7:0] BTC_OFF_MASK   = 8'h0C;
  localparam logic [7:0] BTC_OFF_CFG    = 8'h10;
  localparam logic [7:0] BTC_OFF_COUNT  = 8'h14;
  // ==========================================================
  // Control field positions
  localparam int BTC_BIT_RUN  = 7;
  localparam int BTC_BIT_ONE  = 6;
  localparam int BTC_BIT_TO   = 5;
  localparam int BTC_BIT_PSH  = 4;
  localparam int BTC_BIT_PSL  = 3;
  localparam int BTC_BIT_CAPM = 2;
  // Status / mask bits
  localparam int BTC_EV_TO  = 0;
  localparam int BTC_EV_CAP = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] BTC_RST_BYTE = 8'h00;
  localparam logic [1:0] BTC_RST_EV   = 2'h0;
  localparam logic [2:0] BTC_RST_DIV  = 3'h0;
endpackage

// file: logic/btc_top.sv
// Byte timer control, hold registers and Wishbone slave
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module btc_top
  import btc_pkg::*;
(
  input  wire logic       clk_i,       // 40 MHz clock
  input  wire logic       rst_i,       // Sync reset, high
  input  wire logic       cyc_i,       // Wishbone cycle
  input  wire logic       stb_i,       // Wishbone strobe
  input  wire logic       we_i,        // Write enable
  input  wire logic [7:0] adr_i,       // Byte address
  input  wire logic [3:0] sel_i,       // Byte selects
  input  wire logic [31:0] dat_i,      // Write data
  output logic      [31:0] dat_o,      // Read data
  output logic            ack_o,       // Acknowledge
  input  wire logic       port3_bit1_i, // Edge source pin A
  input  wire logic       port2_bit0_i, // Edge source pin B
  output logic            cap_irq_o,   // Capture interrupt request
  output logic            irq_o        // Summary interrupt
);
  // ==========================================================
  // Registers
  logic [7:0] ctrl;
  logic [7:0] high_level_byte;
  logic [7:0] low_level_byte;
  logic [7:0] wide_low_byte;
  logic [1:0] status;
  logic [1:0] mask;
  logic       edge_src;
  logic [7:0] count;
  logic [2:0] div;
  logic [1:0] pin_a_sync;
  logic [1:0] pin_b_sync;
  logic       pin_last;

  // ==========================================================
  // Bus decode
  wire req     = cyc_i & stb_i & ~ack_o;
  wire wr      = req & we_i & sel_i[0];
  wire hit_ctl = (adr_i == BTC_OFF_CTRL);
  wire hit_low = (adr_i == BTC_OFF_LOW);
  wire hit_hi  = (adr_i == BTC_OFF_HIGH);
  wire hit_wl  = (adr_i == BTC_OFF_WLOW);
  wire hit_st  = (adr_i == BTC_OFF_STATUS);
  wire hit_mk  = (adr_i == BTC_OFF_MASK);
  wire hit_cf  = (adr_i == BTC_OFF_CFG);
  wire hit_cn  = (adr_i == BTC_OFF_COUNT);
  wire [7:0] wd = dat_i[7:0];

  // ==========================================================
  // Prescaler and counter
  wire [1:0] psel = ctrl[BTC_BIT_PSH:BTC_BIT_PSL];
  wire tick = (psel == 2'd0) ? 1'b1 :                         // RULE_04
              (psel == 2'd1) ? (div[0] == 1'b1) :
              (psel == 2'd2) ? (div[1:0] == 2'b11) : (div == 3'b111);
  wire running  = ctrl[BTC_BIT_RUN];
  wire step     = running & tick;
  wire terminal = step & (count == 8'h00);                      // RULE_11

  // Edge detection on the selected pin
  wire pin_sel  = edge_src ? pin_b_sync[1] : pin_a_sync[1];     // RULE_10
  wire cap_ev   = pin_sel & ~pin_last;

  // ==========================================================
  // Next control value
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (wr && hit_ctl) begin
      next_ctrl[BTC_BIT_RUN]                = wd[BTC_BIT_RUN];                 // RULE_01
      next_ctrl[BTC_BIT_ONE]                = wd[BTC_BIT_ONE];                 // RULE_02
      next_ctrl[BTC_BIT_PSH:BTC_BIT_PSL]    = wd[BTC_BIT_PSH:BTC_BIT_PSL];
      next_ctrl[BTC_BIT_CAPM]               = wd[BTC_BIT_CAPM];
      if (wd[BTC_BIT_TO]) begin
        next_ctrl[BTC_BIT_TO] = 1'b0;                                          // RULE_03
      end
    end
    if (terminal) begin
      next_ctrl[BTC_BIT_TO] = 1'b1;                                            // RULE_11
      if (ctrl[BTC_BIT_ONE]) begin
        next_ctrl[BTC_BIT_RUN] = 1'b0;                                         // RULE_12
      end
    end
    next_ctrl[1:0] = 2'b00;
  end

  logic [1:0] next_status;
  always_comb begin
    next_status = status;
    if (wr && hit_st) begin
      next_status = status & ~wd[1:0];
    end
    if (terminal) begin
      next_status[BTC_EV_TO] = 1'b1;
    end
    if (cap_ev && ctrl[BTC_BIT_CAPM]) begin                     // RULE_05 RULE_06
      next_status[BTC_EV_CAP] = 1'b1;
    end
  end

  wire start = wr & hit_ctl & wd[BTC_BIT_RUN] & ~running;
  wire [7:0] next_count = (start | terminal) ? low_level_byte :   // RULE_12
                          step ? count - 8'd1 : count;

  // ==========================================================
  // Read mux
  wire [7:0] rd = hit_ctl ? ctrl :
                  hit_low ? low_level_byte :
                  hit_hi  ? high_level_byte :
                  hit_wl  ? wide_low_byte :
                  hit_st  ? {6'h00, status} :
                  hit_mk  ? {6'h00, mask} :
                  hit_cf  ? {7'h00, edge_src} :
                  hit_cn  ? count : 8'h00;

  // ==========================================================
  // State
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= BTC_RST_BYTE;
      status <= BTC_RST_EV;
      count <= BTC_RST_BYTE;
      div <= BTC_RST_DIV;
      pin_a_sync <= 2'b00;
      pin_b_sync <= 2'b00;
      pin_last <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      count <= next_count;
      div <= div + 3'd1;
      pin_a_sync <= {pin_a_sync[0], port3_bit1_i};
      pin_b_sync <= {pin_b_sync[0], port2_bit0_i};
      pin_last <= pin_sel;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_level_byte <= BTC_RST_BYTE;
      low_level_byte <= BTC_RST_BYTE;
      wide_low_byte <= BTC_RST_BYTE;
      mask <= BTC_RST_EV;
      edge_src <= 1'b0;
    end else if (wr) begin
      if (hit_hi) begin
        high_level_byte <= wd;                                  // RULE_07
      end else if (hit_low) begin
        low_level_byte <= wd;                                   // RULE_08
      end else if (hit_wl) begin
        wide_low_byte <= wd;                                    // RULE_09
      end else if (hit_mk) begin
        mask <= wd[1:0];
      end else if (hit_cf) begin
        edge_src <= wd[0];                                      // RULE_10
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      cap_irq_o <= 1'b0;
    end else begin
      ack_o <= req;
      dat_o <= {24'h00_0000, rd};
      irq_o <= |(next_status & mask);
      cap_irq_o <= next_status[BTC_EV_CAP] & next_ctrl[BTC_BIT_CAPM]; // RULE_05 RULE_06
    end
  end
endmodule

// file: sim/btc_pin_src.sv
// Pin source model for the edge-detect inputs
`timescale 1ns/1ps
module btc_pin_src (
  input  wire logic clk_i,        // Clock
  input  wire logic sel_i,        // Pin choice
  input  wire logic fire_i,       // Pulse request
  output logic      port3_bit1_o, // Pin A
  output logic      port2_bit0_o  // Pin B
);
  // Only the chosen pin moves
  always_ff @(posedge clk_i) begin
    port3_bit1_o <= fire_i && !sel_i;
    port2_bit0_o <= fire_i && sel_i;
  end
endmodule

// file: sim/btc_top_sva.sv
// Port assertions for the byte timer control block
`timescale 1ns/1ps
module btc_top_sva (
  input wire logic        clk_i,     // Clock
  input wire logic        rst_i,     // Reset
  input wire logic        cyc_i,     // Cycle
  input wire logic        stb_i,     // Strobe
  input wire logic        we_i,      // Write
  input wire logic [7:0]  adr_i,     // Address
  input wire logic [3:0]  sel_i,     // Selects
  input wire logic [31:0] dat_i,     // Write data
  input wire logic [31:0] dat_o,     // Read data
  input wire logic        ack_o,     // Ack
  input wire logic        cap_irq_o, // Capture irq
  input wire logic        irq_o      // Irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Capture enable shadow
  logic take, cap_en;
  assign take = cyc_i && stb_i && !ack_o;
  always_ff @(posedge clk_i)
    if (rst_i) cap_en <= 1'b0;
    else if (take && we_i && sel_i[0] && adr_i == 8'h00) cap_en <= dat_i[2];
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_ack_answer: assert property (take |=> ack_o)
    else $error("no ack");
  a_ack_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("stray ack");
  a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper bits set");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !cap_irq_o)
    else $error("outputs after reset");
  a_mask_off: assert property (take && we_i && sel_i[0] && adr_i == 8'h0c &&
    dat_i[1:0] == 2'b00 |=> ##1 !irq_o) else $error("masked irq");
  a_cap_gate: assert property ($rose(cap_irq_o) |-> cap_en)
    else $error("capture irq while masked");
  a_cap_hold: assert property ($fell(cap_irq_o) |->
    $past(we_i && (adr_i == 8'h08 || adr_i == 8'h00)) ||
    $past(we_i && (adr_i == 8'h08 || adr_i == 8'h00), 2)) else $error("capture irq lost");
  a_cap_off: assert property (take && we_i && sel_i[0] && adr_i == 8'h00 &&
    !dat_i[2] |=> !cap_irq_o) else $error("capture irq after mask");
  cover property (take && we_i);
  cover property ($rose(cap_irq_o));
  cover property ($rose(irq_o));
  cover property ($fell(cap_irq_o));
endmodule
bind btc_top btc_top_sva u_sva (.*);

// file: sim/byte_timer_control_bench.sv
// Self-checking bench for the byte timer control block
`timescale 1ns/1ps
module byte_timer_control_bench;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, fire = 0, psel = 0;
  logic [7:0]  adr_i = 0, rd;
  logic [31:0] dat_i = 0, dat_o;
  logic        ack_o, cap_irq_o, irq_o, p31, p20;
  logic [3:0]  sel_i = 4'h1;
  int          num_errors = 0, comparisons = 0, k;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, g, e); end end
  btc_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .port3_bit1_i(p31), .port2_bit0_i(p20), .cap_irq_o, .irq_o);
  btc_pin_src u_pin (.clk_i, .sel_i(psel), .fire_i(fire), .port3_bit1_o(p31),
    .port2_bit0_o(p20));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d = 8'h00);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      if (++k > 20) begin num_errors++; give_verdict(); end
    end while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [7:0] a, e);
    wb(0, a);
    `CHK(rd, e)
  endtask
  task automatic pulse(input logic s, e);
    psel <= s;
    fire <= 1;
    repeat (3) @(posedge clk_i);
    fire <= 0;
    repeat (8) @(posedge clk_i);
    `CHK(cap_irq_o, e)
  endtask
  task automatic s_regs;
    rc(8'h00, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wb(1, 8'(4 + i), 8'(8'ha5 ^ i));
      rc(8'(4 + i), 8'(8'ha5 ^ i));
    end
    rc(8'h07, 8'h00);
    sel_i <= 4'h0;
    wb(1, 8'h04, 8'h5a);
    sel_i <= 4'h1;
    rc(8'h04, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      wb(1, 8'h00, 8'(i << 3));
      rc(8'h00, 8'(i << 3));
    end
  endtask
  task automatic s_single;
    wb(1, 8'h04, 8'h03);
    wb(1, 8'h00, 8'hc0);
    repeat (30) if (rd !== 8'h60) wb(0, 8'h00);
    `CHK(rd, 8'h60)
    wb(1, 8'h00, 8'h40);
    rc(8'h00, 8'h60);
    wb(1, 8'h00, 8'h60);
    rc(8'h00, 8'h40);
    rc(8'h08, 8'h01);
    rc(8'h14, 8'h03);
    wb(1, 8'h0c, 8'h01);
    `CHK(irq_o, 1'b1)
    wb(1, 8'h08, 8'h01);
    `CHK(irq_o, 1'b0)
    wb(1, 8'h0c, 8'h00);
    `CHK(irq_o, 1'b0)
  endtask
  task automatic s_modulo;
    wb(1, 8'h04, 8'h02);
    wb(1, 8'h00, 8'h98);
    repeat (30) if (rd !== 8'hb8) wb(0, 8'h00);
    `CHK(rd, 8'hb8)
    wb(1, 8'h00, 8'h18);
    wb(1, 8'h00, 8'h20);
    rc(8'h00, 8'h00);
  endtask
  task automatic s_capture;
    pulse(0, 0);
    wb(1, 8'h00, 8'h04);
    pulse(0, 1);
    wb(1, 8'h00, 8'h00);
    `CHK(cap_irq_o, 1'b0)
    wb(1, 8'h00, 8'h04);
    `CHK(cap_irq_o, 1'b1)
    wb(1, 8'h08, 8'h02);
    wb(1, 8'h10, 8'h01);
    rc(8'h10, 8'h01);
    pulse(0, 0);
    pulse(1, 1);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    s_regs();
    s_single();
    s_modulo();
    s_capture();
    give_verdict();
  end
endmodule
